// [ebi_consts.svh]
// offsets, field positions, reset values and vector addresses of the bus and interrupt pin logic
// assumes the includer wants plain `define macros, no processes
`ifndef EBI_CONSTS_SVH
`define EBI_CONSTS_SVH

`define EBI_REG_AW        8
`define EBI_DW            16
`define EBI_AW            23
`define EBI_LOW_AW        16
`define EBI_NIRQ          4
`define EBI_NSRC          5
// register offsets
`define EBI_OFF_BANK_SWITCH_CONTROL      8'h00
`define EBI_OFF_MASK      8'h04
`define EBI_OFF_CTRL      8'h08
`define EBI_OFF_PEND      8'h0c
`define EBI_OFF_STAT      8'h10
// field positions
`define EBI_BIT_KEEP      0
`define EBI_BIT_GDIS      0
`define EBI_NMI_IDX       3'h4
// reset values
`define EBI_RST_BANK_SWITCH_CONTROL      1'b0
`define EBI_RST_MASK      4'h0
`define EBI_RST_GDIS      1'b1
// vector locations, low sixteen address lines
`define EBI_VEC_BASE      16'hffc0
// pin synchroniser idle values: control and interrupt pins idle high, wide select and host address lines low
`define EBI_SYNC_RST      24'h7f0000

`endif

// [ebi_pkg.sv]
// types shared by the bus and interrupt pin logic
// assumes nothing of its surroundings
package ebi_pkg;
    typedef enum logic [1:0] {
        EBI_IDLE = 2'b00,
        EBI_ACC  = 2'b01,
        EBI_VEC  = 2'b10,
        EBI_HOLD = 2'b11
    } ebi_state_e;

    typedef enum logic [1:0] {
        EBI_SP_PROG = 2'b00,
        EBI_SP_DATA = 2'b01,
        EBI_SP_IO   = 2'b10
    } ebi_space_e;
endpackage

// [ebi_sync.sv]
// three-flop pin synchroniser with agreement filter, one per bit
// assumes pins asynchronous to sys_clk_i; ce_i freezes all state
`timescale 1ns/1ps
`default_nettype none
module ebi_sync
    import ebi_pkg::*;
#(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         sys_clk_i,
    input  wire logic         nrst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_q, s2_q, s3_q, out_q;
            logic s1_d, s2_d, s3_d, out_d;
            // shift chain; output follows once stages two and three agree
            always_comb begin
                s1_d  = pin_i[g];
                s2_d  = s1_q;
                s3_d  = s2_q;
                out_d = (s2_q == s3_q) ? s3_q : out_q;
            end
            always_ff @(posedge sys_clk_i) begin
                if (!nrst_i) begin
                    s1_q  <= RST_VAL[g];
                    s2_q  <= RST_VAL[g];
                    s3_q  <= RST_VAL[g];
                    out_q <= RST_VAL[g];
                end else if (ce_i) begin
                    s1_q  <= s1_d;
                    s2_q  <= s2_d;
                    s3_q  <= s3_d;
                    out_q <= out_d;
                end
            end
            assign sync_o[g] = out_q;
        end
    endgenerate
endmodule // ebi_sync
`default_nettype wire

// [ebi_prio.sv]
// priority pick among pending sources: nonmaskable first, then lowest input number
// assumes requests already masked by the caller
`timescale 1ns/1ps
`default_nettype none
`include "ebi_consts.svh"
module ebi_prio
    import ebi_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  nrst_i,
    input  wire logic [`EBI_NSRC-1:0]  req_i,
    output logic                       valid_o,
    output logic      [2:0]            num_o
);
    // scan downward so the lowest external input wins
    always_comb begin
        valid_o = |req_i;
        num_o   = 3'h0;
        for (int i = `EBI_NIRQ - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                num_o = 3'(i);
            end
        end
        if (req_i[`EBI_NSRC-1]) begin
            num_o = `EBI_NMI_IDX;
        end
    end

    a_prio_nmi: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        req_i[`EBI_NSRC-1] |-> num_o == `EBI_NMI_IDX)
        else $error("nonmaskable source not picked first");
    a_prio_lowest: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (req_i[0] && !req_i[`EBI_NSRC-1]) |-> num_o == 3'h0)
        else $error("input zero not picked first");
endmodule // ebi_prio
`default_nettype wire

// [ebi_top.sv]
// external parallel bus pins and external interrupt inputs of the core
// assumes one clock sys_clk_i at 125 MHz, synchronous active-low reset, core-side request port
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ebi_consts.svh"
module ebi_top
    import ebi_pkg::*;
(
    input  wire logic                    sys_clk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    ce_i,
    // register port
    input  wire logic [`EBI_REG_AW-1:0]  reg_addr_i,
    input  wire logic [`EBI_DW-1:0]      reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    output logic      [`EBI_DW-1:0]      reg_rdata_o,
    output logic                         irq_o,
    // core side
    input  wire logic                    acc_req_i,
    input  wire logic [1:0]              acc_space_i,
    input  wire logic                    acc_wr_i,
    input  wire logic [`EBI_AW-1:0]      acc_addr_i,
    input  wire logic [`EBI_DW-1:0]      acc_wdata_i,
    output logic                         acc_ready_o,
    output logic      [`EBI_DW-1:0]      acc_rdata_o,
    output logic                         acc_rvalid_o,
    output logic                         irq_take_o,
    output logic      [2:0]              irq_num_o,
    output logic      [`EBI_LOW_AW-1:0]  host_addr_o,
    // pins
    output logic      [`EBI_AW-1:0]      ext_addr_bus_o,
    output logic      [`EBI_AW-1:0]      ext_addr_bus_oe_o,
    input  wire logic [`EBI_LOW_AW-1:0]  ext_addr_bus_i,
    output logic      [`EBI_DW-1:0]      ext_data_bus_o,
    output logic                         ext_data_bus_oe_o,
    input  wire logic [`EBI_DW-1:0]      ext_data_bus_i,
    output logic      [`EBI_DW-1:0]      ext_data_keep_o,
    output logic                         ext_data_keep_en_o,
    input  wire logic                    host_port_wide_select_i,
    input  wire logic                    out_float_n_i,
    input  wire logic                    hold_req_n_i,
    output logic                         bus_grant_ack_o,
    output logic                         bus_grant_ack_oe_o,
    input  wire logic [`EBI_NIRQ-1:0]    ext_irq_lines_n_i,
    input  wire logic                    nmi_n_i,
    output logic                         irq_taken_strobe_n_o,
    output logic                         irq_taken_strobe_oe_o
);
    // synchronised pins
    logic [23:0]              sync_w;
    logic                     wide_s, float_n_s, hold_n_s, nmi_n_s;
    logic [`EBI_NIRQ-1:0]     irq_n_s;
    logic [`EBI_LOW_AW-1:0]   haddr_s;

    ebi_sync #(.W(24), .RST_VAL(`EBI_SYNC_RST)) u_sync (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .ce_i      (ce_i),
        .pin_i     ({host_port_wide_select_i, out_float_n_i, hold_req_n_i, nmi_n_i,
                     ext_irq_lines_n_i, ext_addr_bus_i}),
        .sync_o    (sync_w)
    );
    assign {wide_s, float_n_s, hold_n_s, nmi_n_s, irq_n_s, haddr_s} = sync_w;

    // state
    ebi_state_e               state_q, state_d;
    logic [1:0]               space_q, space_d;
    logic                     wr_q, wr_d;
    logic [`EBI_AW-1:0]       addr_q, addr_d;
    logic [`EBI_DW-1:0]       wdat_q, wdat_d;
    logic [`EBI_DW-1:0]       rdat_q, rdat_d;
    logic                     rval_q, rval_d;
    logic [`EBI_DW-1:0]       last_q, last_d;
    logic                     take_q, take_d;
    logic [2:0]               num_q, num_d;
    logic                     irq_taken_strobe_n_q, irq_taken_strobe_n_d;
    logic [`EBI_LOW_AW-1:0]   haddr_q, haddr_d;
    // registers and flags
    logic                     keep_q, keep_d;
    logic [`EBI_NIRQ-1:0]     mask_q, mask_d;
    logic                     gdis_q, gdis_d;
    logic [`EBI_NSRC-1:0]     pend_q, pend_d;
    logic [`EBI_NSRC-1:0]     lvl_q, lvl_d;
    logic [`EBI_DW-1:0]       rd_q, rd_d;

    logic [`EBI_NSRC-1:0]     fall_w, req_w;
    logic                     pick_v;
    logic [2:0]               pick_n;
    logic                     float_w, hold_want;

    // asserting edge of each synchronised interrupt level
    assign fall_w    = lvl_d & ~lvl_q;
    assign lvl_d     = {~nmi_n_s, ~irq_n_s};
    assign hold_want = ~hold_n_s;
    assign float_w   = (state_q == EBI_HOLD) | ~float_n_s;

    // masking: external inputs by mask and global disable, nonmaskable never
    assign req_w = {pend_q[`EBI_NSRC-1],
                    pend_q[`EBI_NIRQ-1:0] & mask_q & {`EBI_NIRQ{~gdis_q}}};

    ebi_prio u_prio (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .req_i     (req_w),
        .valid_o   (pick_v),
        .num_o     (pick_n)
    );

    assign acc_ready_o = ce_i & (state_q == EBI_IDLE) & ~hold_want & ~pick_v;

    // bus sequencing: hold first, then interrupt vector fetch, then core access
    always_comb begin
        state_d  = state_q;
        space_d  = space_q;
        wr_d     = wr_q;
        addr_d   = addr_q;
        wdat_d   = wdat_q;
        rdat_d   = rdat_q;
        rval_d   = 1'b0;
        last_d   = last_q;
        take_d   = 1'b0;
        num_d    = num_q;
        irq_taken_strobe_n_d = 1'b1;
        haddr_d  = wide_s ? haddr_s : haddr_q;
        case (state_q)
            EBI_IDLE: begin
                if (hold_want) begin
                    state_d = EBI_HOLD;
                end else if (pick_v) begin
                    state_d  = EBI_VEC;
                    space_d  = EBI_SP_PROG;
                    wr_d     = 1'b0;
                    addr_d   = {7'h0, `EBI_VEC_BASE | {11'h0, pick_n, 2'b00}};
                    num_d    = pick_n;
                    take_d   = 1'b1;
                    irq_taken_strobe_n_d = 1'b0;
                end else if (acc_req_i) begin
                    state_d = EBI_ACC;
                    space_d = acc_space_i;
                    wr_d    = acc_wr_i;
                    addr_d  = acc_addr_i;
                    wdat_d  = acc_wdata_i;
                end
            end
            EBI_ACC: begin
                state_d = EBI_IDLE;
                if (wr_q) begin
                    last_d = ext_data_bus_oe_o ? wdat_q : last_q;
                end else begin
                    rdat_d = ext_data_bus_i;
                    rval_d = 1'b1;
                    last_d = ext_data_bus_i;
                end
            end
            EBI_VEC: state_d = EBI_IDLE;
            EBI_HOLD: begin
                if (!hold_want) begin
                    state_d = EBI_IDLE;
                end
            end
            default: state_d = EBI_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state_q  <= EBI_IDLE;
            space_q  <= EBI_SP_PROG;
            wr_q     <= 1'b0;
            addr_q   <= '0;
            wdat_q   <= '0;
            rdat_q   <= '0;
            rval_q   <= 1'b0;
            last_q   <= '0;
            take_q   <= 1'b0;
            num_q    <= 3'h0;
            irq_taken_strobe_n_q <= 1'b1;
            haddr_q  <= '0;
        end else if (ce_i) begin
            state_q  <= state_d;
            space_q  <= space_d;
            wr_q     <= wr_d;
            addr_q   <= addr_d;
            wdat_q   <= wdat_d;
            rdat_q   <= rdat_d;
            rval_q   <= rval_d;
            last_q   <= last_d;
            take_q   <= take_d;
            num_q    <= num_d;
            irq_taken_strobe_n_q <= irq_taken_strobe_n_d;
            haddr_q  <= haddr_d;
        end
    end

    // register file: write-one-to-clear pending flags, set wins over clear
    always_comb begin
        keep_d = keep_q;
        mask_d = mask_q;
        gdis_d = gdis_q;
        pend_d = pend_q;
        rd_d   = '0;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `EBI_OFF_BANK_SWITCH_CONTROL: keep_d = reg_wdata_i[`EBI_BIT_KEEP];
                `EBI_OFF_MASK: mask_d = reg_wdata_i[`EBI_NIRQ-1:0];
                `EBI_OFF_CTRL: gdis_d = reg_wdata_i[`EBI_BIT_GDIS];
                `EBI_OFF_PEND: pend_d = pend_q & ~reg_wdata_i[`EBI_NSRC-1:0];
                default: ;
            endcase
        end
        if (take_d) begin
            pend_d[pick_n] = 1'b0;
        end
        pend_d = pend_d | fall_w;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `EBI_OFF_BANK_SWITCH_CONTROL: rd_d = {15'h0, keep_q};
                `EBI_OFF_MASK: rd_d = {12'h0, mask_q};
                `EBI_OFF_CTRL: rd_d = {15'h0, gdis_q};
                `EBI_OFF_PEND: rd_d = {11'h0, pend_q};
                `EBI_OFF_STAT: rd_d = {13'h0, wide_s, ~float_n_s, state_q == EBI_HOLD};
                default:       rd_d = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            keep_q <= `EBI_RST_BANK_SWITCH_CONTROL;
            mask_q <= `EBI_RST_MASK;
            gdis_q <= `EBI_RST_GDIS;
            pend_q <= '0;
            lvl_q  <= '0;
            rd_q   <= '0;
        end else if (ce_i) begin
            keep_q <= keep_d;
            mask_q <= mask_d;
            gdis_q <= gdis_d;
            pend_q <= pend_d;
            lvl_q  <= lvl_d;
            rd_q   <= rd_d;
        end
    end

    // outputs
    assign reg_rdata_o  = rd_q;
    assign irq_o        = |req_w;
    assign acc_rdata_o  = rdat_q;
    assign acc_rvalid_o = rval_q;
    assign irq_take_o   = take_q;
    assign irq_num_o    = num_q;
    assign host_addr_o  = haddr_q;

    // address pins: low lines on every access outside wide host select and float, upper lines only for program space
    assign ext_addr_bus_o = addr_q;
    assign ext_addr_bus_oe_o[`EBI_LOW_AW-1:0] =
        {`EBI_LOW_AW{(state_q == EBI_ACC || state_q == EBI_VEC) & ~float_w & ~wide_s}};
    assign ext_addr_bus_oe_o[`EBI_AW-1:`EBI_LOW_AW] =
        {7{(state_q == EBI_ACC) & (space_q == EBI_SP_PROG) & ~float_w}};

    // data pins: driven only while writing, with keepers filling undriven time
    assign ext_data_bus_o     = wdat_q;
    assign ext_data_bus_oe_o  = nrst_i & (state_q == EBI_ACC) & wr_q & ~float_w
                                & ~hold_want;
    assign ext_data_keep_o    = last_q;
    assign ext_data_keep_en_o = keep_q & ~ext_data_bus_oe_o;

    // grant and acknowledge pins float while the float pin is low
    assign bus_grant_ack_o       = (state_q == EBI_HOLD);
    assign bus_grant_ack_oe_o    = float_n_s;
    assign irq_taken_strobe_n_o  = irq_taken_strobe_n_q;
    assign irq_taken_strobe_oe_o = float_n_s;

    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_vec_pick;
        (state_q == EBI_IDLE) && ce_i && !hold_want && pick_v;
    endsequence
    sequence s_vec_out;
        !irq_taken_strobe_n_q && ext_addr_bus_o[`EBI_LOW_AW-1:0] == (`EBI_VEC_BASE | {11'h0, num_q, 2'b00});
    endsequence

    a_addr_float: assert property (float_w |-> ext_addr_bus_oe_o == '0)
        else $error("address lines driven while floated");
    a_upper_prog: assert property (|ext_addr_bus_oe_o[`EBI_AW-1:`EBI_LOW_AW] |->
        space_q == EBI_SP_PROG && state_q == EBI_ACC)
        else $error("upper address lines driven outside program space");
    a_host_wide: assert property (wide_s |-> ext_addr_bus_oe_o[`EBI_LOW_AW-1:0] == '0)
        else $error("low address lines driven in wide host mode");
    a_data_float: assert property ((hold_want || !float_n_s || !wr_q) |->
        !ext_data_bus_oe_o)
        else $error("data bus driven when it must float");
    a_keep_reset: assert property ($rose(nrst_i) |-> !ext_data_keep_en_o)
        else $error("keepers enabled out of reset");
    a_irq_taken_strobe_vector: assert property (s_vec_pick |=> s_vec_out ##1 irq_taken_strobe_n_q)
        else $error("acknowledge not paired with vector address");
    a_nmi_unblock: assert property ((pend_q[`EBI_NSRC-1] && state_q == EBI_IDLE && ce_i
        && !hold_want) |=> take_q && num_q == `EBI_NMI_IDX)
        else $error("nonmaskable flag blocked");
    a_flag_edge: assert property ((ce_i && |fall_w) |=> |(pend_q & $past(fall_w)))
        else $error("asserting edge lost");
    a_grant_float: assert property (bus_grant_ack_o |->
        ext_addr_bus_oe_o == '0 && !ext_data_bus_oe_o)
        else $error("grant given with lines still driven");
endmodule // ebi_top
`default_nettype wire

// [ebi_ext_mem.sv]
// far side of the pins: external memory, host address driver, bus-hold requester
// assumes one clock; bench sets the host address and the wish for hold
`timescale 1ns/1ps
`default_nettype none
module ebi_ext_mem
    import ebi_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_n_i,
    input  wire logic [22:0] addr_i,
    input  wire logic [22:0] addr_oe_i,
    input  wire logic [15:0] data_i,
    input  wire logic        data_oe_i,
    input  wire logic [15:0] keep_i,
    input  wire logic        keep_en_i,
    input  wire logic [15:0] host_addr_i,
    input  wire logic        hold_want_i,
    output logic      [15:0] addr_pin_o,
    output logic      [15:0] data_pin_o,
    output logic             hold_req_n_o
);
    logic [15:0] last_q;
    logic        rd_en;
    // memory answers while the address is driven and the data bus is free
    assign rd_en = addr_oe_i[0] && !data_oe_i;
    // resolved data wire; a free, unheld line shows a changing pattern
    assign data_pin_o = data_oe_i ? data_i :
                        rd_en ? {addr_i[7:0], ~addr_i[7:0]} :
                        keep_en_i ? keep_i : ~last_q;
    // host drives the low lines whenever the device does not
    assign addr_pin_o = addr_oe_i[0] ? addr_i[15:0] : host_addr_i;
    assign hold_req_n_o = !hold_want_i;
    // last level seen on the data wire
    always_ff @(posedge sys_clk_i) begin
        last_q <= nrst_n_i ? data_pin_o : 16'h0000;
    end
endmodule // ebi_ext_mem
`default_nettype wire

// [ext_bus_and_irq_pin_logic_tb_top.sv]
// self-checking bench of the bus and interrupt pin logic
// assumes the external memory model on the far side; one 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "ebi_consts.svh"
module ext_bus_and_irq_pin_logic_tb_top
    import ebi_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        nrst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, acc_wdata = 16'h0000, acc_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, acc_req = 1'b0, acc_wr = 1'b0;
    logic [1:0]  acc_space = 2'h0;
    logic [22:0] acc_addr = 23'h000000, addr_o, addr_oe;
    logic [15:0] host_addr = 16'h0000, host_addr_o, addr_pin, data_pin, data_o, keep_o;
    logic        wide = 1'b0, float_n = 1'b1, hold_want = 1'b0, nmi_n = 1'b1;
    logic [3:0]  irq_n = 4'hf;
    logic        irq_o, ready, rvalid, take, data_oe, keep_en, hold_req_n;
    logic        grant, grant_oe, irq_taken_strobe_n, irq_taken_strobe_oe;
    logic [2:0]  num;
    int          err_count = 0, check_count = 0, i;

    // 8 ns clock
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    ebi_top dut_u (.sys_clk_i(sys_clk), .nrst_i(nrst_n), .ce_i(1'b1), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .irq_o(irq_o), .acc_req_i(acc_req), .acc_space_i(acc_space), .acc_wr_i(acc_wr),
        .acc_addr_i(acc_addr), .acc_wdata_i(acc_wdata), .acc_ready_o(ready),
        .acc_rdata_o(acc_rdata), .acc_rvalid_o(rvalid), .irq_take_o(take), .irq_num_o(num),
        .host_addr_o(host_addr_o), .ext_addr_bus_o(addr_o), .ext_addr_bus_oe_o(addr_oe),
        .ext_addr_bus_i(addr_pin), .ext_data_bus_o(data_o), .ext_data_bus_oe_o(data_oe),
        .ext_data_bus_i(data_pin), .ext_data_keep_o(keep_o), .ext_data_keep_en_o(keep_en),
        .host_port_wide_select_i(wide), .out_float_n_i(float_n), .hold_req_n_i(hold_req_n),
        .bus_grant_ack_o(grant), .bus_grant_ack_oe_o(grant_oe), .ext_irq_lines_n_i(irq_n),
        .nmi_n_i(nmi_n), .irq_taken_strobe_n_o(irq_taken_strobe_n), .irq_taken_strobe_oe_o(irq_taken_strobe_oe));

    ebi_ext_mem mem_u (.sys_clk_i(sys_clk), .nrst_n_i(nrst_n), .addr_i(addr_o),
        .addr_oe_i(addr_oe), .data_i(data_o), .data_oe_i(data_oe), .keep_i(keep_o),
        .keep_en_i(keep_en), .host_addr_i(host_addr), .hold_want_i(hold_want),
        .addr_pin_o(addr_pin), .data_pin_o(data_pin), .hold_req_n_o(hold_req_n));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_wr_t(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_rd_t(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg read", reg_rdata, exp);
    endtask

    // one core access; pins checked in its pin cycle, read data one cycle later
    task automatic acc(input logic [1:0] sp, input logic wr, input logic [22:0] a,
                       input logic [15:0] d, input logic [22:0] exp_oe, input logic exp_doe);
        @(posedge sys_clk);
        acc_req <= 1'b1;
        acc_space <= sp;
        acc_wr <= wr;
        acc_addr <= a;
        acc_wdata <= d;
        @(posedge sys_clk);
        acc_req <= 1'b0;
        #1;
        check("addr oe", addr_oe, exp_oe);
        check("addr", addr_o & exp_oe, a & exp_oe);
        check("data oe", data_oe, exp_doe);
        if (exp_doe) check("data out", data_o, d);
        @(posedge sys_clk);
        #1;
        if (!wr && exp_oe[0]) check("read data", {rvalid, acc_rdata}, {1'b1, a[7:0], ~a[7:0]});
    endtask

    // waits for a taken interrupt and checks number, strobe and vector address
    task automatic wait_take(input logic [2:0] n);
        for (i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            #1;
            if (take === 1'b1) break;
        end
        check("irq num", {take, irq_taken_strobe_n, num}, {2'b10, n});
        check("vector", addr_o[15:0], 16'hffc0 | (16'(n) << 2));
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        finish_test();
    end

    initial begin
        repeat (11) @(posedge sys_clk);
        #1;
        check("reset pins", {data_oe, keep_en, addr_oe}, 23'h0);
        @(posedge sys_clk);
        nrst_n <= 1'b1;
        reg_rd_t(`EBI_OFF_BANK_SWITCH_CONTROL, 16'h0000);
        reg_rd_t(`EBI_OFF_MASK, 16'h0000);
        reg_rd_t(`EBI_OFF_CTRL, 16'h0001);
        reg_rd_t(8'h14, 16'h0000);
        // accesses in each space
        acc(EBI_SP_PROG, 1'b0, 23'h5a0031, 16'h0, 23'h7fffff, 1'b0);
        acc(EBI_SP_DATA, 1'b1, 23'h123456, 16'hbeef, 23'h00ffff, 1'b1);
        acc(EBI_SP_IO, 1'b0, 23'h7f00c3, 16'h0, 23'h00ffff, 1'b0);
        // keeper enable and held level
        reg_wr_t(`EBI_OFF_BANK_SWITCH_CONTROL, 16'h0001);
        acc(EBI_SP_DATA, 1'b1, 23'h000010, 16'ha5a5, 23'h00ffff, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1;
        check("keeper", {keep_en, data_pin}, {1'b1, 16'ha5a5});
        reg_wr_t(`EBI_OFF_BANK_SWITCH_CONTROL, 16'h0000);
        #1;
        check("keeper off", keep_en, 1'b0);
        // masked input stays pending; clear stays clear while line is low
        @(posedge sys_clk);
        irq_n <= 4'he;
        repeat (8) @(posedge sys_clk);
        #1;
        check("masked irq", {take, irq_o}, 2'b00);
        reg_rd_t(`EBI_OFF_PEND, 16'h0001);
        reg_wr_t(`EBI_OFF_PEND, 16'h0001);
        reg_rd_t(`EBI_OFF_PEND, 16'h0000);
        // two unmasked inputs at once, one masked input beside them
        reg_wr_t(`EBI_OFF_MASK, 16'h000a);
        reg_wr_t(`EBI_OFF_CTRL, 16'h0000);
        @(posedge sys_clk);
        irq_n <= 4'hf;
        repeat (3) @(posedge sys_clk);
        irq_n <= 4'h4;
        wait_take(3'h1);
        check("irq level", irq_o, 1'b1);
        wait_take(3'h3);
        check("irq level", irq_o, 1'b0);
        reg_rd_t(`EBI_OFF_PEND, 16'h0001);
        reg_wr_t(`EBI_OFF_PEND, 16'h0001);
        // nonmaskable input under global disable and empty mask
        reg_wr_t(`EBI_OFF_MASK, 16'h0000);
        reg_wr_t(`EBI_OFF_CTRL, 16'h0001);
        irq_n <= 4'hf;
        nmi_n <= 1'b0;
        wait_take(`EBI_NMI_IDX);
        @(posedge sys_clk);
        nmi_n <= 1'b1;
        // bus hold
        hold_want <= 1'b1;
        for (i = 0; i < 20 && grant !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check("hold", {grant, ready, data_oe, addr_oe}, {3'b100, 23'h0});
        reg_rd_t(`EBI_OFF_STAT, 16'h0001);
        @(posedge sys_clk);
        hold_want <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        check("hold off", {grant, ready}, 2'b01);
        // global float
        @(posedge sys_clk);
        float_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        check("float oe", {grant_oe, irq_taken_strobe_oe}, 2'b00);
        acc(EBI_SP_DATA, 1'b1, 23'h000020, 16'h5555, 23'h0, 1'b0);
        @(posedge sys_clk);
        float_n <= 1'b1;
        // wide host select: low lines become inputs
        wide <= 1'b1;
        host_addr <= 16'h1234;
        repeat (6) @(posedge sys_clk);
        #1;
        check("host addr", host_addr_o, 16'h1234);
        reg_rd_t(`EBI_OFF_STAT, 16'h0004);
        acc(EBI_SP_PROG, 1'b0, 23'h7f0002, 16'h0, 23'h7f0000, 1'b0);
        finish_test();
    end
endmodule // ext_bus_and_irq_pin_logic_tb_top
`default_nettype wire
